/* src/ext_bus_consts.vh */
// constants for the external bus mastership block
// Functional notes
// RQ1 - The request output goes active while an external access is wanted and drops after.
// RQ2 - With request_hold_bit set the request output stays active with no access pending.
// RQ3 - In stop or wait the request output is inactive if hold is 0 and keeps its level if 1.
// RQ4 - Only external access needs move the request output, never internal bus activity.
// RQ5 - Reset holds the request output inactive and puts the arbiter in the slave state.
// RQ6 - The outside arbiter changes the grant input only in step with core_clock_out.
// RQ7 - The outside arbiter drives grant active to name this device the next master.
// RQ8 - With grant active the device waits for the busy line to be inactive before mastering.
// RQ9 - When grant is removed the device leaves mastership at the end of the current bus cycle.
// RQ10 - Every master drives the busy line active while it uses the bus, in step with the clock.
// RQ11 - A pending master takes the bus only after busy goes inactive, then drives busy itself.
// RQ12 - A master may park, holding busy active after its accesses and reusing the bus.
// RQ13 - Busy is released by driving it high for a cycle and then letting it float.
// RQ14 - As master the column strobe is driven; off master with enable bit clear it floats.
// RQ15 - As master the bus clock runs only while bus_clock_enable_bit is set.
// RQ16 - A running bus clock leads core_clock_out by a quarter of a clock period.
// RQ17 - As master the inverted bus clock is the bus clock complement, else it floats.
`ifndef EXT_BUS_CONSTS_VH
`define EXT_BUS_CONSTS_VH

// ****************************************
// arbitration states
// ****************************************
`define ST_W        2
`define ST_SLAVE    2'h0
`define ST_MASTER   2'h1
`define ST_RELEASE  2'h2

// ****************************************
// clock phase generator
// ****************************************
`define PH_W        2
`define PH_RST      2'h0
`define PH_STEP     2'h1
`define PH_BUS_HI0  2'h1
`define PH_BUS_HI1  2'h2
`define PH_CORE_HI0 2'h2
`define PH_CORE_HI1 2'h3

// ****************************************
// pin levels
// ****************************************
`define LVL_HI      1'h1
`define LVL_LO      1'h0
`define SYNC_RST    3'h7

`endif

/* src/external_bus_mastership.v */
// external bus arbitration, busy line, column strobe and bus clock outputs
`timescale 1ns/1ps
`include "ext_bus_consts.vh"

module external_bus_mastership (
    clk_sys,
    nrst,
    clk_en,
    ext_access_req,
    cycle_end,
    stop_wait,
    request_hold_bit,
    mastership_enable_bit,
    bus_clock_enable_bit,
    column_strobe_req,
    bus_grant_n_in,
    busy_n_in,
    bus_request_n_out,
    busy_n_out,
    busy_oe_n,
    column_strobe_n_out,
    column_strobe_oe_n,
    bus_clock_out,
    bus_clock_oe_n,
    bus_clock_n_out,
    bus_clock_n_oe_n,
    core_clock_out,
    is_master
);
    input  wire clk_sys;
    input  wire nrst;
    input  wire clk_en;
    input  wire ext_access_req;
    input  wire cycle_end;
    input  wire stop_wait;
    input  wire request_hold_bit;
    input  wire mastership_enable_bit;
    input  wire bus_clock_enable_bit;
    input  wire column_strobe_req;
    input  wire bus_grant_n_in;
    input  wire busy_n_in;
    output reg  bus_request_n_out;
    output reg  busy_n_out;
    output reg  busy_oe_n;
    output reg  column_strobe_n_out;
    output reg  column_strobe_oe_n;
    output reg  bus_clock_out;
    output reg  bus_clock_oe_n;
    output reg  bus_clock_n_out;
    output reg  bus_clock_n_oe_n;
    output reg  core_clock_out;
    output reg  is_master;

    // ****************************************
    // pin synchronisers
    // ****************************************
    // three stages; a change counts once stages two and three agree
    reg  [2:0]          grant_sync_q;
    reg  [2:0]          busy_sync_q;
    reg                 grant_n_q;
    reg                 busy_seen_n_q;

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            grant_sync_q  <= `SYNC_RST;
            busy_sync_q   <= `SYNC_RST;
            grant_n_q     <= `LVL_HI;
            busy_seen_n_q <= `LVL_HI;
        end else if (clk_en) begin
            grant_sync_q <= {grant_sync_q[1:0], bus_grant_n_in};
            busy_sync_q  <= {busy_sync_q[1:0], busy_n_in};
            if (grant_sync_q[1] == grant_sync_q[2]) begin
                grant_n_q <= grant_sync_q[2];
            end
            if (busy_sync_q[1] == busy_sync_q[2]) begin
                busy_seen_n_q <= busy_sync_q[2];
            end
        end
    end

    wire granted   = ~grant_n_q;
    wire bus_free  = busy_seen_n_q;

    // ****************************************
    // arbitration state machine
    // ****************************************
    reg  [`ST_W-1:0]    state_q;
    reg  [`ST_W-1:0]    state_d;
    reg                 in_cycle_q;
    reg                 in_cycle_d;
    wire                cycle_done;

    // a master with no cycle open can hand over at once; an open cycle waits for cycle_end
    assign cycle_done = ~in_cycle_q | cycle_end;

    always @* begin
        state_d    = state_q;
        in_cycle_d = in_cycle_q;
        case (state_q)
            `ST_SLAVE: begin
                in_cycle_d = `LVL_LO;
                if (ext_access_req && granted && bus_free) begin // RQ8 RQ11
                    state_d    = `ST_MASTER;
                    in_cycle_d = `LVL_HI;
                end
            end
            `ST_MASTER: begin
                if (cycle_end) begin
                    in_cycle_d = `LVL_LO;
                end
                // a request in the closing cycle opens the next one: set wins
                if (ext_access_req) begin
                    in_cycle_d = `LVL_HI;
                end
                // stays here with no access while granted: bus parking
                if (!granted && cycle_done) begin // RQ9 RQ12
                    state_d    = `ST_RELEASE;
                    in_cycle_d = `LVL_LO;
                end
            end
            `ST_RELEASE: begin
                in_cycle_d = `LVL_LO;
                state_d    = `ST_SLAVE; // RQ13
            end
            default: begin
                in_cycle_d = `LVL_LO;
                state_d    = `ST_SLAVE;
            end
        endcase
    end

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_q    <= `ST_SLAVE; // RQ5
            in_cycle_q <= `LVL_LO;
        end else if (clk_en) begin
            state_q    <= state_d;
            in_cycle_q <= in_cycle_d;
        end
    end

    wire master_d = (state_d == `ST_MASTER);

    // ****************************************
    // bus request
    // ****************************************
    // only external access needs and the hold bit feed this term
    reg req_n_d;

    always @* begin
        req_n_d = ~(ext_access_req | request_hold_bit); // RQ1 RQ2 RQ4
        if (stop_wait) begin
            req_n_d = request_hold_bit ? bus_request_n_out : `LVL_HI; // RQ3
        end
    end

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            bus_request_n_out <= `LVL_HI; // RQ5
        end else if (clk_en) begin
            bus_request_n_out <= req_n_d;
        end
    end

    // ****************************************
    // busy line and mastership status
    // ****************************************
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            busy_n_out <= `LVL_HI;
            busy_oe_n  <= `LVL_HI;
            is_master  <= `LVL_LO;
        end else if (clk_en) begin
            is_master <= master_d;
            case (state_d)
                `ST_MASTER: begin
                    busy_n_out <= `LVL_LO; // RQ10 RQ11
                    busy_oe_n  <= `LVL_LO;
                end
                `ST_RELEASE: begin
                    // active pull-up: drive high first, then float
                    busy_n_out <= `LVL_HI; // RQ13
                    busy_oe_n  <= `LVL_LO;
                end
                default: begin
                    busy_n_out <= `LVL_HI;
                    busy_oe_n  <= `LVL_HI; // RQ13
                end
            endcase
        end
    end

    // ****************************************
    // phase generator
    // ****************************************
    // core and bus clocks run at a quarter of clk_sys so a quarter lead is one step
    reg  [`PH_W-1:0]    phase_q;
    wire [`PH_W-1:0]    phase_d = phase_q + `PH_STEP;
    wire core_hi_d = (phase_d == `PH_CORE_HI0) | (phase_d == `PH_CORE_HI1);
    wire bus_hi_d  = (phase_d == `PH_BUS_HI0) | (phase_d == `PH_BUS_HI1);

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            phase_q        <= `PH_RST;
            core_clock_out <= `LVL_LO;
        end else if (clk_en) begin
            phase_q        <= phase_d;
            core_clock_out <= core_hi_d;
        end
    end

    // ****************************************
    // column strobe and bus clock outputs
    // ****************************************
    wire bus_clk_run = master_d & bus_clock_enable_bit; // RQ15

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            column_strobe_n_out <= `LVL_HI;
            column_strobe_oe_n  <= `LVL_HI;
            bus_clock_out       <= `LVL_LO;
            bus_clock_oe_n      <= `LVL_HI;
            bus_clock_n_out     <= `LVL_HI;
            bus_clock_n_oe_n    <= `LVL_HI;
        end else if (clk_en) begin
            // off master with the enable bit set the strobe is held inactive
            column_strobe_n_out <= master_d ? ~column_strobe_req : `LVL_HI; // RQ14
            column_strobe_oe_n  <= ~(master_d | mastership_enable_bit); // RQ14
            bus_clock_out       <= bus_clk_run & bus_hi_d; // RQ15 RQ16
            bus_clock_oe_n      <= ~master_d;
            bus_clock_n_out     <= ~(bus_clk_run & bus_hi_d); // RQ17
            bus_clock_n_oe_n    <= ~master_d; // RQ17
        end
    end

endmodule

/* verif/ext_arbiter_model.sv */
// arbitration circuit and second master sharing the busy line
`timescale 1ns/1ps
module ext_arbiter_model (
    input  wire logic core_clock_out,
    input  wire logic give_grant,
    input  wire logic other_busy,
    input  wire logic busy_n_out,
    input  wire logic busy_oe_n,
    output logic      bus_grant_n_in,
    output wire logic busy_n_in
);
    initial bus_grant_n_in = 1'h1;
    // grant moves only on the core clock edge
    always @(posedge core_clock_out) bus_grant_n_in <= ~give_grant;
    // released line floats up through the pull-up
    assign busy_n_in = other_busy ? 1'h0 : (busy_oe_n ? 1'h1 : busy_n_out);
endmodule

/* verif/external_bus_mastership_checker.sv */
// port properties of the bus mastership block
`timescale 1ns/1ps
module external_bus_mastership_checker (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic ext_access_req,
    input wire logic cycle_end,
    input wire logic stop_wait,
    input wire logic request_hold_bit,
    input wire logic mastership_enable_bit,
    input wire logic bus_clock_enable_bit,
    input wire logic column_strobe_req,
    input wire logic bus_grant_n_in,
    input wire logic busy_n_in,
    input wire logic bus_request_n_out,
    input wire logic busy_n_out,
    input wire logic busy_oe_n,
    input wire logic column_strobe_n_out,
    input wire logic column_strobe_oe_n,
    input wire logic bus_clock_out,
    input wire logic bus_clock_oe_n,
    input wire logic bus_clock_n_out,
    input wire logic bus_clock_n_oe_n,
    input wire logic core_clock_out,
    input wire logic is_master
);
    // pins pass three sync stages and an agree register: the deciding sample is five back
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    a_req_follow: assert property (clk_en && !stop_wait |=>
        bus_request_n_out == !($past(ext_access_req) || $past(request_hold_bit)))
        else $error("request level wrong");
    a_stop_drop: assert property (clk_en && stop_wait && !request_hold_bit |=>
        bus_request_n_out) else $error("request not dropped in stop");
    a_stop_keep: assert property (clk_en && stop_wait && request_hold_bit |=>
        $stable(bus_request_n_out)) else $error("request moved in stop");
    a_reset_idle: assert property ($rose(nrst) |-> bus_request_n_out && !is_master)
        else $error("reset state wrong");
    a_take_free: assert property ($rose(is_master) |->
        $past(busy_n_in, 5) && !$past(bus_grant_n_in, 5)) else $error("took busy bus");
    a_master_busy: assert property (is_master |-> !busy_oe_n && !busy_n_out)
        else $error("master not driving busy");
    a_leave_ungrant: assert property ($fell(is_master) |-> $past(bus_grant_n_in, 5))
        else $error("left while granted");
    a_busy_pullup: assert property ($fell(is_master) |->
        !busy_oe_n && busy_n_out ##1 busy_oe_n) else $error("busy release wrong");
    a_strobe_float: assert property (!mastership_enable_bit ##1 !is_master |->
        column_strobe_oe_n) else $error("strobe driven off master");
    a_bclk_lead: assert property ($rose(bus_clock_out) |->
        !bus_clock_oe_n ##1 $rose(core_clock_out)) else $error("bus clock phase wrong");
    a_bclk_inv: assert property (!bus_clock_n_oe_n |-> bus_clock_n_out != bus_clock_out)
        else $error("inverted clock wrong");
    c_take: cover property ($rose(is_master));
    c_leave: cover property ($fell(is_master));
    c_stop_hold: cover property (stop_wait && request_hold_bit && !bus_request_n_out);
    c_bclk_run: cover property ($rose(bus_clock_out));
endmodule
bind external_bus_mastership external_bus_mastership_checker u_chk (.*);

/* verif/external_bus_mastership_test.sv */
// self-checking bench for the bus mastership block
`timescale 1ns/1ps
module external_bus_mastership_test;
    logic clk_sys = 1'h0, nrst = 1'h0, clk_en = 1'h1, ext_access_req = 1'h0;
    logic cycle_end = 1'h0, stop_wait = 1'h0, request_hold_bit = 1'h0;
    logic mastership_enable_bit = 1'h0, bus_clock_enable_bit = 1'h1;
    logic column_strobe_req = 1'h0, give_grant = 1'h0, other_busy = 1'h0;
    wire  bus_grant_n_in, busy_n_in, bus_request_n_out, busy_n_out, busy_oe_n;
    wire  column_strobe_n_out, column_strobe_oe_n, bus_clock_out, bus_clock_oe_n;
    wire  bus_clock_n_out, bus_clock_n_oe_n, core_clock_out, is_master;
    int   n_mismatch = 0, num_checks = 0, cyc = 0;
    always #25 clk_sys = ~clk_sys;
    external_bus_mastership u_dut (.*);
    ext_arbiter_model u_arb (.core_clock_out(core_clock_out), .give_grant(give_grant),
        .other_busy(other_busy), .busy_n_out(busy_n_out), .busy_oe_n(busy_oe_n),
        .bus_grant_n_in(bus_grant_n_in), .busy_n_in(busy_n_in));
    task automatic chk(input string nm, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %b seen %b", nm, exp, got);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic wait_master(input logic v);
        for (int i = 0; i < 40 && is_master !== v; i++) @(negedge clk_sys);
        chk("is_master", v, is_master);
    endtask
    task automatic results;
        $display("mismatches %0d checks %0d", n_mismatch, num_checks);
        if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic t_request;
        ext_access_req = 1'h1;
        ticks(1);
        chk("request", 1'h0, bus_request_n_out);
        clk_en = 1'h0;
        ext_access_req = 1'h0;
        ticks(2);
        chk("frozen", 1'h0, bus_request_n_out);
        clk_en = 1'h1;
        ticks(1);
        chk("request", 1'h1, bus_request_n_out);
        request_hold_bit = 1'h1;
        ticks(1);
        chk("hold", 1'h0, bus_request_n_out);
        stop_wait = 1'h1;
        ticks(2);
        chk("stop hold", 1'h0, bus_request_n_out);
        request_hold_bit = 1'h0;
        ticks(1);
        chk("stop", 1'h1, bus_request_n_out);
        stop_wait = 1'h0;
    endtask
    task automatic t_master;
        int hi;
        logic prev;
        other_busy = 1'h1;
        give_grant = 1'h1;
        ext_access_req = 1'h1;
        ticks(20);
        chk("busy held", 1'h0, is_master);
        other_busy = 1'h0;
        wait_master(1'h1);
        chk("busy pin", 1'h0, busy_n_in);
        ext_access_req = 1'h0;
        column_strobe_req = 1'h1;
        ticks(8);
        chk("parked", 1'h1, is_master);
        chk("strobe", 1'h0, column_strobe_n_out);
        chk("bclk_n", ~bus_clock_out, bus_clock_n_out);
        chk("bclk oe", 1'h0, bus_clock_oe_n);
        hi = 0;
        for (int i = 0; i < 4; i++) begin
            hi += bus_clock_out;
            prev = bus_clock_out;
            ticks(1);
            chk("core lead", prev, core_clock_out);
        end
        chk("bclk runs", 1'h1, hi == 2);
        bus_clock_enable_bit = 1'h0;
        ticks(4);
        chk("bclk stop", 1'h0, bus_clock_out);
    endtask
    task automatic t_release;
        mastership_enable_bit = 1'h1;
        give_grant = 1'h0;
        ticks(12);
        chk("open cycle", 1'h1, is_master);
        cycle_end = 1'h1;
        ticks(1);
        cycle_end = 1'h0;
        ticks(2);
        chk("released", 1'h0, is_master);
        chk("pull-up", 1'h1, busy_n_in);
        chk("busy oe", 1'h1, busy_oe_n);
        chk("strobe idle", 1'h1, column_strobe_n_out);
        chk("strobe oe", 1'h0, column_strobe_oe_n);
        chk("bclk_n oe", 1'h1, bus_clock_n_oe_n);
        chk("bclk oe", 1'h1, bus_clock_oe_n);
    endtask
    initial begin
        ticks(4);
        chk("reset req", 1'h1, bus_request_n_out);
        chk("reset master", 1'h0, is_master);
        ticks(4);
        nrst = 1'h1;
        ticks(1);
        t_request();
        t_master();
        t_release();
        results();
    end
    // a hung handshake would otherwise stall the run forever
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            results();
        end
    end
endmodule
